/* rtl/splf_defines.svh */
// Register offsets, field positions, reset values and lane counts
// for the STN pixel stage.
// Assumes inclusion by bare name from files under rtl/.
`ifndef SPLF_DEFINES_SVH
`define SPLF_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define SPLF_OFF_RED 8'h00
`define SPLF_OFF_GREEN 8'h04
`define SPLF_OFF_BLUE 8'h08
`define SPLF_OFF_CTRL 8'h0c
`define SPLF_OFF_STATUS 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPLF_CTRL_EN_BIT 0
`define SPLF_CTRL_MODE_LSB 1
`define SPLF_CTRL_MODE_MSB 3
`define SPLF_CTRL_SCAN_LSB 4
`define SPLF_CTRL_SCAN_MSB 5
`define SPLF_STAT_UNDERRUN_BIT 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPLF_RED_RESET 32'h00000000
`define SPLF_GREEN_RESET 32'h00000000
`define SPLF_BLUE_RESET 16'h0000

// ----------------------------------------------------------------
// Word and lane sizes
// ----------------------------------------------------------------
`define SPLF_WORD_END 6'h20
`define SPLF_LANES_NARROW 4'h4
`define SPLF_LANES_WIDE 4'h8

`endif

/* rtl/splf_pkg.sv */
// Types shared by the STN pixel stage: modes, scan types, states
// and the packed state carriers of the register slave and the video stage.
// Assumes splf_defines.svh is available for the constants.
package splf_pkg;

    typedef enum logic [2:0] {
        SPLF_MONO = 3'h0,
        SPLF_GRAY4 = 3'h1,
        SPLF_GRAY16 = 3'h2,
        SPLF_C256 = 3'h3,
        SPLF_C4096 = 3'h4
    } splf_mode_t;

    typedef enum logic [1:0] {
        SPLF_DUAL4 = 2'h0,
        SPLF_SINGLE4 = 2'h1,
        SPLF_SINGLE8 = 2'h2
    } splf_scan_t;

    typedef enum logic [1:0] {
        SPLF_BUS_IDLE = 2'b01,
        SPLF_BUS_ANSWER = 2'b10
    } splf_bus_state_t;

    typedef struct packed {
        logic valid;
        logic [31:0] word;
    } splf_fifo_word_t;

    typedef struct packed {
        logic [31:0] red;
        logic [31:0] green;
        logic [15:0] blue;
        logic enable;
        splf_mode_t mode;
        splf_scan_t scan;
    } splf_cfg_t;

    typedef struct packed {
        splf_bus_state_t state;
        splf_cfg_t cfg;
        logic underrun;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } splf_bus_regs_t;

    typedef struct packed {
        logic [31:0] word;
        logic have;
        logic [4:0] pos;
        logic [1:0] comp;
        logic [3:0] seq;
        logic [7:0] stg;
        logic [3:0] cnt;
        logic ready;
    } splf_half_t;

    typedef struct packed {
        logic [1:0] vclk_sync;
        logic vclk_last;
        logic [1:0] fs_sync;
        logic fs_last;
        logic [3:0] frame;
        splf_half_t [1:0] half;
        logic [7:0] data;
        logic underrun_pulse;
    } splf_stage_t;

endpackage

/* rtl/splf_dither_duty_unit.sv */
// Frame duty control for one sub-pixel: gray level, frame count and
// a dither offset in, pixel on or off out. Purely combinational.
// Assumes its inputs come from registers on the same clock.
`timescale 1ns/1ps
module splf_dither_duty_unit import splf_pkg::*; (
    input wire logic [3:0] level,
    input wire logic [3:0] frame,
    input wire logic [3:0] offset,
    output logic pixel_on
);

    logic [3:0] num;
    logic [3:0] per;
    logic [4:0] phase_sum;
    logic [4:0] phase;
    logic [7:0] spread;
    logic [7:0] spread_rem;

    // ------------------------------------------------------------
    // Duty table
    // ------------------------------------------------------------
    // on-frames per period
    always_comb begin
        num = 4'h0;
        per = 4'h1;
        case (level)
            4'hf: {num, per} = 8'h11;
            4'he: {num, per} = 8'h67;
            4'hd: {num, per} = 8'h45;
            4'hc: {num, per} = 8'h34;
            4'hb: {num, per} = 8'h57;
            4'ha: {num, per} = 8'h23;
            4'h9: {num, per} = 8'h35;
            4'h8: {num, per} = 8'h47;
            4'h7: {num, per} = 8'h12;
            4'h6: {num, per} = 8'h37;
            4'h5: {num, per} = 8'h25;
            4'h4: {num, per} = 8'h13;
            4'h3: {num, per} = 8'h14;
            4'h2: {num, per} = 8'h15;
            4'h1: {num, per} = 8'h17;
            default: {num, per} = 8'h01;
        endcase
    end

    // ------------------------------------------------------------
    // Phase and spreading
    // ------------------------------------------------------------
    // frame phase selects on or off
    assign phase_sum = {1'b0, frame} + {1'b0, offset};
    assign phase = phase_sum % {1'b0, per};
    assign spread = {3'h0, phase} * {4'h0, num};
    assign spread_rem = spread % {4'h0, per};
    assign pixel_on = (spread_rem < {4'h0, num});

endmodule

/* rtl/splf_apb_regs.sv */
// APB register slave for the STN pixel stage: level tables, control
// and status. One wait state on every access.
// Assumes an APB master on clk and a stage that reports its events.
`timescale 1ns/1ps
`include "splf_defines.svh"
module splf_apb_regs import splf_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output splf_cfg_t cfg,
    input wire logic [3:0] frame_count,
    input wire logic underrun_event
);

    splf_bus_regs_t r;
    splf_bus_regs_t next_r;
    logic mapped;
    logic [31:0] rd_word;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    always_comb begin
        mapped = 1'b1;
        rd_word = 32'h00000000;
        case (paddr)
            `SPLF_OFF_RED: rd_word = r.cfg.red;
            `SPLF_OFF_GREEN: rd_word = r.cfg.green;
            `SPLF_OFF_BLUE: rd_word = {16'h0000, r.cfg.blue};
            `SPLF_OFF_CTRL: rd_word = {26'h0, r.cfg.scan, r.cfg.mode,
                                       r.cfg.enable};
            `SPLF_OFF_STATUS: rd_word = {27'h0, r.underrun, frame_count};
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        case (r.state)
            SPLF_BUS_IDLE: begin
                if (psel && penable) begin
                    next_r.state = SPLF_BUS_ANSWER;
                    next_r.pready = 1'b1;
                    next_r.pslverr = ~mapped;
                    next_r.prdata = pwrite ? 32'h00000000 : rd_word;
                end
            end
            SPLF_BUS_ANSWER: begin
                next_r.state = SPLF_BUS_IDLE;
                if (psel && penable && pwrite && mapped) begin
                    case (paddr)
                        `SPLF_OFF_RED: next_r.cfg.red = pwdata;
                        `SPLF_OFF_GREEN: next_r.cfg.green = pwdata;
                        `SPLF_OFF_BLUE: next_r.cfg.blue = pwdata[15:0];
                        `SPLF_OFF_CTRL: begin
                            next_r.cfg.enable = pwdata[`SPLF_CTRL_EN_BIT];
                            next_r.cfg.mode = splf_mode_t'(
                                pwdata[`SPLF_CTRL_MODE_MSB:`SPLF_CTRL_MODE_LSB]);
                            next_r.cfg.scan = splf_scan_t'(
                                pwdata[`SPLF_CTRL_SCAN_MSB:`SPLF_CTRL_SCAN_LSB]);
                        end
                        `SPLF_OFF_STATUS: begin
                            if (pwdata[`SPLF_STAT_UNDERRUN_BIT]) begin
                                next_r.underrun = 1'b0;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            default: next_r.state = SPLF_BUS_IDLE;
        endcase
        // Set after clear so a same-cycle event survives
        if (underrun_event) begin
            next_r.underrun = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r.state <= SPLF_BUS_IDLE;
            r.cfg.red <= `SPLF_RED_RESET;
            r.cfg.green <= `SPLF_GREEN_RESET;
            r.cfg.blue <= `SPLF_BLUE_RESET;
            r.cfg.enable <= 1'b0;
            r.cfg.mode <= SPLF_MONO;
            r.cfg.scan <= SPLF_DUAL4;
            r.underrun <= 1'b0;
            r.pready <= 1'b0;
            r.pslverr <= 1'b0;
            r.prdata <= 32'h00000000;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign cfg = r.cfg;

endmodule

/* rtl/splf_video_stage.sv */
// Top of the STN pixel stage: unpacks FIFO words, maps them through
// the level tables, applies frame duty control and packs the result
// onto the 8-bit panel bus. Holds the APB slave and duty units.
// Assumes panel_vclk and frame_sync arrive from another domain and
// that the FIFOs present words with a valid flag on clk.
`timescale 1ns/1ps
`include "splf_defines.svh"
module splf_video_stage import splf_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic panel_vclk,
    input wire logic frame_sync,
    input wire splf_fifo_word_t upper_pixel_fifo,
    output logic upper_pixel_fifo_ready,
    input wire splf_fifo_word_t lower_pixel_fifo,
    output logic lower_pixel_fifo_ready,
    output logic [7:0] panel_data_out
);

    splf_stage_t st;
    splf_stage_t next_st;
    splf_cfg_t cfg;
    logic [3:0] level [2];
    logic on_bit [2];
    logic fifo_valid [2];
    logic [31:0] fifo_word [2];

    // ------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------
    splf_apb_regs u_regs (
        .clk(clk),
        .reset_n(reset_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .cfg(cfg),
        .frame_count(st.frame),
        .underrun_event(st.underrun_pulse)
    );

    // ------------------------------------------------------------
    // Pixel decode helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] top_byte(input splf_half_t hs);
        logic [31:0] shifted;
        shifted = hs.word << hs.pos;
        return shifted[31:24];
    endfunction

    function automatic logic [3:0] decode_level(input splf_half_t hs,
                                                input splf_cfg_t c);
        logic [7:0] b;
        b = top_byte(hs);
        case (c.mode)
            SPLF_GRAY4: decode_level = c.blue[{b[7:6], 2'b00} +: 4];
            SPLF_GRAY16: decode_level = b[7:4];
            SPLF_C4096: decode_level = b[7:4];
            SPLF_C256: begin
                case (hs.comp)
                    2'h0: decode_level = c.red[{b[7:5], 2'b00} +: 4];
                    2'h1: decode_level = c.green[{b[4:2], 2'b00} +: 4];
                    default: decode_level = c.blue[{b[1:0], 2'b00} +: 4];
                endcase
            end
            default: decode_level = 4'h0;
        endcase
    endfunction

    function automatic logic [5:0] step_bits(input splf_half_t hs,
                                             input splf_mode_t m);
        case (m)
            SPLF_MONO: step_bits = 6'h01;
            SPLF_GRAY4: step_bits = 6'h02;
            SPLF_GRAY16: step_bits = 6'h04;
            SPLF_C4096: step_bits = 6'h04;
            SPLF_C256: step_bits = (hs.comp == 2'h2) ? 6'h08 : 6'h00;
            default: step_bits = 6'h01;
        endcase
    endfunction

    assign fifo_valid[0] = upper_pixel_fifo.valid;
    assign fifo_valid[1] = lower_pixel_fifo.valid;
    assign fifo_word[0] = upper_pixel_fifo.word;
    assign fifo_word[1] = lower_pixel_fifo.word;

    // ------------------------------------------------------------
    // Duty units, one per panel half
    // ------------------------------------------------------------
    for (genvar h = 0; h < 2; h++) begin : g_half
        assign level[h] = decode_level(st.half[h], cfg);
        splf_dither_duty_unit u_duty (
            .level(level[h]),
            .frame(st.frame),
            .offset(st.half[h].seq),
            .pixel_on(on_bit[h])
        );
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic vclk_fall;
        logic fs_rise;
        logic dual;
        logic active;
        logic out_bit;
        logic filled;
        logic [3:0] need;
        logic [5:0] psum;
        splf_half_t hs;
        logic [7:0] raw;
        vclk_fall = 1'b0;
        fs_rise = 1'b0;
        dual = 1'b0;
        active = 1'b0;
        out_bit = 1'b0;
        filled = 1'b0;
        need = `SPLF_LANES_NARROW;
        psum = 6'h00;
        hs = '0;
        raw = 8'h00;

        next_st = st;
        next_st.underrun_pulse = 1'b0;
        // Only the second stage is read: first may be metastable
        next_st.vclk_sync = {st.vclk_sync[0], panel_vclk};
        next_st.vclk_last = st.vclk_sync[1];
        next_st.fs_sync = {st.fs_sync[0], frame_sync};
        next_st.fs_last = st.fs_sync[1];
        vclk_fall = st.vclk_last & ~st.vclk_sync[1];
        fs_rise = st.fs_sync[1] & ~st.fs_last;

        if (fs_rise) begin
            next_st.frame = st.frame + 4'h1;
        end

        // lanes per pixel clock by scan type
        dual = (cfg.scan == SPLF_DUAL4);
        need = (cfg.scan == SPLF_SINGLE8) ? `SPLF_LANES_WIDE
                                          : `SPLF_LANES_NARROW;

        if (!cfg.enable) begin
            next_st.half = '0;
            // Blank only on a link fall so data keeps its hold time
            if (vclk_fall) begin
                next_st.data = 8'h00;
            end
        end else begin
            for (int h = 0; h < 2; h++) begin
                hs = st.half[h];
                // lower FIFO only in dual scan
                active = (h == 0) || dual;
                next_st.half[h].ready = active && !hs.have && !hs.ready;
                if (hs.ready && fifo_valid[h] && !hs.have) begin
                    next_st.half[h].word = fifo_word[h];
                    next_st.half[h].have = 1'b1;
                    next_st.half[h].pos = 5'h00;
                    next_st.half[h].comp = 2'h0;
                end else if (hs.have && (hs.cnt < need) && !vclk_fall) begin
                    // mono takes raw bits, no duty
                    raw = top_byte(hs);
                    out_bit = (cfg.mode == SPLF_MONO) ? raw[7] : on_bit[h];
                    next_st.half[h].stg = {hs.stg[6:0], out_bit};
                    next_st.half[h].cnt = hs.cnt + 4'h1;
                    next_st.half[h].seq = hs.seq + 4'h1;
                    if (cfg.mode == SPLF_C256) begin
                        next_st.half[h].comp = (hs.comp == 2'h2) ? 2'h0
                                              : hs.comp + 2'h1;
                    end
                    psum = {1'b0, hs.pos} + step_bits(hs, cfg.mode);
                    if (psum == `SPLF_WORD_END) begin
                        next_st.half[h].have = 1'b0;
                        next_st.half[h].pos = 5'h00;
                    end else begin
                        next_st.half[h].pos = psum[4:0];
                    end
                end
            end

            if (vclk_fall) begin
                filled = (st.half[0].cnt >= need) &&
                         (!dual || (st.half[1].cnt >= need));
                if (filled) begin
                    next_st.half[0].cnt = 4'h0;
                    next_st.half[1].cnt = 4'h0;
                    case (cfg.scan)
                        // upper half high, lower half low
                        SPLF_DUAL4: next_st.data = {st.half[0].stg[3:0],
                                                    st.half[1].stg[3:0]};
                        // low four lines, high lines idle
                        SPLF_SINGLE4: next_st.data = {4'h0,
                                                      st.half[0].stg[3:0]};
                        SPLF_SINGLE8: next_st.data = st.half[0].stg;
                        default: next_st.data = 8'h00;
                    endcase
                end else begin
                    // Starved lanes keep old data; flagged to software
                    next_st.underrun_pulse = 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign upper_pixel_fifo_ready = st.half[0].ready;
    assign lower_pixel_fifo_ready = st.half[1].ready;
    assign panel_data_out = st.data;

endmodule

/* testbench/splf_video_stage_properties.sv */
// Port checker for the STN pixel stage: bus answer, upper FIFO pulls and
// panel data timing. Assumes a bind onto splf_video_stage.
`timescale 1ns/1ps
module splf_video_stage_properties import splf_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic panel_vclk,
    input wire splf_fifo_word_t upper_pixel_fifo,
    input wire logic upper_pixel_fifo_ready,
    input wire logic [7:0] panel_data_out
);
    // --------
    // Helper
    // --------
    logic [3:0] vclk_age;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Saturates, so an idle link never wraps back into range
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vclk_age <= 4'hf;
        end else if ($fell(panel_vclk)) begin
            vclk_age <= 4'h0;
        end else if (vclk_age != 4'hf) begin
            vclk_age <= vclk_age + 4'h1;
        end
    end
    // --------
    // Properties
    // --------
    a_ready_one_wait: assert property (
        $rose(penable) && psel |=> pready) else $error("late answer");
    a_ready_pulse: assert property (
        pready |=> !pready) else $error("ready too long");
    a_ready_cause: assert property (
        pready |-> $past(psel && penable)) else $error("stray ready");
    a_err_in_ready: assert property (
        pslverr |-> pready) else $error("error without ready");
    a_rdata_holds: assert property (
        $changed(prdata) |-> pready) else $error("read data moved");
    a_fifo_pulse: assert property (
        upper_pixel_fifo_ready |=> !upper_pixel_fifo_ready)
        else $error("fifo ready too long");
    a_take_then_wait: assert property (
        upper_pixel_fifo_ready && upper_pixel_fifo.valid
        |=> !upper_pixel_fifo_ready [*3]) else $error("word not used");
    a_data_after_vclk: assert property (
        $changed(panel_data_out) |-> vclk_age inside {[1:6]})
        else $error("data moved off the link clock");
    c_error: cover property (pslverr);
    c_take: cover property (upper_pixel_fifo_ready && upper_pixel_fifo.valid);
    c_data: cover property ($changed(panel_data_out));
endmodule
bind splf_video_stage splf_video_stage_properties u_props (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .panel_vclk(panel_vclk), .upper_pixel_fifo(upper_pixel_fifo),
    .upper_pixel_fifo_ready(upper_pixel_fifo_ready),
    .panel_data_out(panel_data_out));

/* testbench/splf_panel_model.sv */
// Panel driver model: link clock only inside frames, frame start,
// bus latched on each rising link clock.
// Assumes the bench holds run high while frames should flow.
`timescale 1ns/1ps
module splf_panel_model (
    input wire logic run,
    input wire logic [7:0] panel_data_out,
    output logic panel_vclk,
    output logic frame_sync,
    output logic [7:0] seen,
    output int frames
);
    initial begin
        panel_vclk = 1'b0;
        frame_sync = 1'b0;
        seen = 8'h00;
        frames = 0;
        forever begin
            wait (run);
            frame_sync = 1'b1;
            frames++;
            for (int i = 0; i < 16; i++) begin
                #62.5 panel_vclk = 1'b1;
                seen = panel_data_out;
                #62.5 panel_vclk = 1'b0;
                frame_sync = 1'b0;
            end
            // Link clock stands still between frames
            #250;
        end
    end
endmodule

/* testbench/tb.sv */
// Bench for the STN pixel stage: APB tasks, panel model, and mode
// sequences compared on the panel bus.
// Assumes the design under rtl/ and splf_panel_model.
`timescale 1ns/1ps
`include "splf_defines.svh"
module tb;
    import splf_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, panel_vclk, frame_sync, up_rdy, lo_rdy;
    logic run = 1'b0;
    splf_fifo_word_t upper = '0;
    splf_fifo_word_t lower = '0;
    logic [7:0] panel_data, seen;
    int frames;
    int err_total = 0;
    int num_checks = 0;
    int lo_pulls = 0;
    int lo_base = 0;

    always #2.5 clk = ~clk;
    // Lower FIFO pulls, to prove single scan leaves it alone
    always @(negedge clk) begin
        if (lo_rdy === 1'b1) begin
            lo_pulls++;
        end
    end

    splf_video_stage dut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .panel_vclk(panel_vclk),
        .frame_sync(frame_sync), .upper_pixel_fifo(upper),
        .upper_pixel_fifo_ready(up_rdy), .lower_pixel_fifo(lower),
        .lower_pixel_fifo_ready(lo_rdy), .panel_data_out(panel_data));
    splf_panel_model pm (.run(run), .panel_data_out(panel_data),
        .panel_vclk(panel_vclk), .frame_sync(frame_sync), .seen(seen),
        .frames(frames));

    // --------
    // Tasks
    // --------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", n, exp, got);
        end
    endtask
    // Holds the request until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                       input string n);
        apb(1'b0, a, 32'h0);
        check(n, rd, exp);
    endtask
    // Patterns chosen so every link clock shows the same bus value, or with pop set the same count of ones
    task automatic show(input splf_mode_t m, input splf_scan_t s,
                        input logic [31:0] up, lo, input logic [7:0] exp,
                        input bit pop, input string n);
        apb(1'b1, `SPLF_OFF_CTRL, 32'h0);
        upper <= '{1'b1, up};
        lower <= '{1'b1, lo};
        apb(1'b1, `SPLF_OFF_CTRL, {26'h0, s, m, 1'b1});
        lo_base = lo_pulls;
        run = 1'b1;
        repeat (40) @(posedge panel_vclk);
        repeat (4) begin
            @(posedge panel_vclk);
            #1;
            check(n, pop ? 32'($countones(seen)) : {24'h0, seen},
                  {24'h0, exp});
        end
        check(n, {31'h0, lo_pulls != lo_base},
              {31'h0, s == SPLF_DUAL4});
        $display("test %s done", n);
    endtask

    // --------
    // Sequence
    // --------
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        rdc(`SPLF_OFF_RED, `SPLF_RED_RESET, "red reset");
        rdc(`SPLF_OFF_GREEN, `SPLF_GREEN_RESET, "green reset");
        rdc(`SPLF_OFF_BLUE, {16'h0, `SPLF_BLUE_RESET}, "blue reset");
        rdc(`SPLF_OFF_STATUS, 32'h0, "status reset");
        apb(1'b1, `SPLF_OFF_BLUE, 32'hffffffff);
        rdc(`SPLF_OFF_BLUE, 32'h0000ffff, "blue width");
        rdc(8'h14, 32'h0, "unmapped data");
        check("unmapped err", {31'h0, er}, 32'h1);
        run = 1'b1;
        wait (frames == 3);
        run = 1'b0;
        repeat (600) @(posedge clk);
        apb(1'b0, `SPLF_OFF_STATUS, 32'h0);
        check("frame count", rd & 32'hf, 32'h3);
        $display("test registers done");
        apb(1'b1, `SPLF_OFF_RED, 32'h0000f000);
        rdc(`SPLF_OFF_RED, 32'h0000f000, "red rw");
        apb(1'b1, `SPLF_OFF_GREEN, 32'h0f000000);
        apb(1'b1, `SPLF_OFF_BLUE, 32'h0000f0f0);
        show(SPLF_MONO, SPLF_SINGLE8, 32'ha5a5a5a5, 32'h0, 8'ha5, 1'b0,
             "mono8");
        show(SPLF_MONO, SPLF_SINGLE4, 32'h55555555, 32'h0, 8'h05, 1'b0,
             "mono4");
        show(SPLF_MONO, SPLF_DUAL4, 32'h33333333, 32'hcccccccc, 8'h3c,
             1'b0, "mono dual");
        show(SPLF_GRAY4, SPLF_SINGLE4, 32'h6c6c6c6c, 32'h0, 8'h0a, 1'b0,
             "gray4");
        show(SPLF_GRAY16, SPLF_DUAL4, 32'hffffffff, 32'h0, 8'hf0, 1'b0,
             "gray16 dual");
        show(SPLF_C256, SPLF_SINGLE8, 32'h79797979, 32'h0, 8'hff, 1'b0,
             "c256");
        show(SPLF_C4096, SPLF_SINGLE4, 32'hf0f0f0f0, 32'h0, 8'h0a, 1'b0,
             "c4096");
        show(SPLF_GRAY16, SPLF_SINGLE4, 32'h77777777, 32'h0, 8'h02, 1'b1,
             "half duty");
        show(SPLF_GRAY16, splf_scan_t'(2'h3), 32'hffffffff, 32'h0, 8'h00,
             1'b0, "no scan");
        apb(1'b1, `SPLF_OFF_STATUS, 32'h10);
        apb(1'b0, `SPLF_OFF_STATUS, 32'h0);
        check("underrun clear", rd & 32'h10, 32'h0);
        upper <= '0;
        repeat (200) @(posedge clk);
        apb(1'b0, `SPLF_OFF_STATUS, 32'h0);
        check("underrun set", rd & 32'h10, 32'h10);
        $display("test underrun done");
        report_and_stop();
    end

    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end
endmodule
